// file: testbench/lnbfs_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// bus master in the host's place; its clock stands high between frames
module lnbfs_host_model (
  // open drain pins, a one releases the line
  output logic      scl,
  output logic      sda_drv,
  // resolved data line with pull-up
  input  wire logic sda_line
);
  localparam int HALF = 1000;  // 10 ref cycles, well above the 600 ns phase minimum

  // idle bus before the first frame
  initial
  begin
    scl     = 1'h1;
    sda_drv = 1'h1;
  end

  // data falls while the clock is high
  task automatic start_bit();
    sda_drv = 1'h0;
    #(HALF);
    scl = 1'h0;
  endtask : start_bit

  // data rises while the clock is high, then the bus idles
  task automatic stop_bit();
    sda_drv = 1'h0;
    #(HALF);
    scl = 1'h1;
    #(HALF);
    sda_drv = 1'h1;
    #(HALF);
  endtask : stop_bit

  // data set while the clock is low, sampled at the end of the high phase
  task automatic bit_slot(input logic b, output logic got);
    sda_drv = b;
    #(HALF);
    scl = 1'h1;
    #(HALF);
    got = sda_line;
    scl = 1'h0;
  endtask : bit_slot

  // eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--)
    begin
      bit_slot(tx[i], rx[i]);
    end
    bit_slot(ack_in, ack_out);
  endtask : xfer
endmodule : lnbfs_host_model
`default_nettype wire

// file: testbench/lnbfs_status_regs_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// port-level watch on the status block, ref_clk domain only
module lnbfs_chk #(
  parameter logic [19:0] OC_LIMIT_CYC = 20'h75300
) (
  // clock and reset
  input wire logic                   ref_clk,
  input wire logic                   reset_n,
  // control and regulator steering
  input wire lnbfs_pkg::lnbfs_ctrl_t ctrl,
  input wire logic [1:0]             out_enable,
  input wire logic [1:0]             linreg_off,
  input wire logic [1:0]             test_src_on,
  input wire logic                   write_end,
  // status bytes
  input wire logic [7:0]             fault_status_primary,
  input wire logic [7:0]             link_status_secondary
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // the write-end strobe lasts exactly one cycle
  sequence s_strobe;
    write_end ##1 !write_end;
  endsequence

  // output-off and power-bad track the output state
  off_set_a: assert property ($fell(out_enable[0]) |-> ##[0:1] fault_status_primary[0])
    else $error("output went off without its flag");
  pb_live_a: assert property (!out_enable[0] [*2] |-> fault_status_primary[4])
    else $error("power bad low while output off");
  wr_clear_a: assert property (write_end && out_enable[0] |-> !fault_status_primary[0])
    else $error("output-off flag kept after enabling write");
  strobe_a: assert property ($rose(write_end) |-> s_strobe)
    else $error("write end strobe not one cycle");
  // output 2 only comes back through a host write, never by itself
  no_self_on_a: assert property ($rose(out_enable[1]) |-> write_end)
    else $error("output enabled without a write");
  // faults switch outputs off together with their flags
  oc_trip_a: assert property ($rose(fault_status_primary[2]) |->
    fault_status_primary[0] && !out_enable[0])
    else $error("overcurrent flag without output off");
  ot_off_a: assert property ($rose(fault_status_primary[6]) |->
    fault_status_primary[1:0] == 2'h3 && out_enable == 2'h0)
    else $error("overtemperature left an output on");
  uv_off_a: assert property ($rose(fault_status_primary[7]) |->
    fault_status_primary[1:0] == 2'h3 && out_enable == 2'h0)
    else $error("undervoltage left an output on");
  upper_zero_a: assert property (link_status_secondary[7:4] == 4'h0)
    else $error("unused secondary bits set");
  // regulator steering: cable test or off turns the linear stage off
  linreg_a: assert property (linreg_off == (~out_enable | $past(ctrl.cable_test)) &&
    (test_src_on & ~$past(ctrl.cable_test)) == 2'h0)
    else $error("regulator steering wrong");
endmodule : lnbfs_chk

bind lnbfs_status_regs lnbfs_chk #(.OC_LIMIT_CYC(OC_LIMIT_CYC)) lnbfs_chk_i (
  .ref_clk(ref_clk), .reset_n(reset_n), .ctrl(ctrl), .out_enable(out_enable),
  .linreg_off(linreg_off), .test_src_on(test_src_on), .write_end(write_end),
  .fault_status_primary(fault_status_primary),
  .link_status_secondary(link_status_secondary));
`default_nettype wire

// file: testbench/lnbfs_status_regs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// self-checking bench for the status block
module lnbfs_status_regs_tb_top;
  localparam logic [19:0] OC_SIM = 20'h00014;  // 20 cycles keeps the run short
  localparam logic [6:0]  ADDR   = lnbfs_pkg::DEV_ADDR_DFLT;
  logic                    ref_clk, reset_n, scl, sda_drv, sda_line, sda_oe_n, write_end;
  logic [1:0]              out_enable, linreg_off, test_src_on;
  logic [7:0]              prim, sec;
  lnbfs_pkg::lnbfs_sense_t sense;
  lnbfs_pkg::lnbfs_ctrl_t  ctrl;
  int                      errors, checks_done, cycles;

  // pull-up on data, either party may pull it low
  assign sda_line = sda_drv & sda_oe_n;

  lnbfs_status_regs #(.OC_LIMIT_CYC(OC_SIM)) lnbfs_status_regs_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .link_clk(scl), .sda_in(sda_line), .sda_out(),
    .sda_oe_n(sda_oe_n), .sense_raw(sense), .ctrl(ctrl), .out_enable(out_enable),
    .linreg_off(linreg_off), .test_src_on(test_src_on), .write_end(write_end),
    .fault_status_primary(prim), .link_status_secondary(sec));
  lnbfs_host_model lnbfs_host_model_i (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));

  initial
  begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end

  // cycle ceiling, about six times the planned run
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      errors++;
      close_out();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  // whole read transaction, master acks every byte but the last
  task automatic bus_read(input int n, input logic [7:0] exp [3]);
    logic [7:0] rx;
    logic       ack;
    lnbfs_host_model_i.start_bit();
    lnbfs_host_model_i.xfer({ADDR, 1'h1}, 1'h1, rx, ack);
    for (int i = 0; i < n; i++)
    begin
      lnbfs_host_model_i.xfer(8'hFF, i == n - 1, rx, ack);
      check("read byte", rx, exp[i]);
    end
    lnbfs_host_model_i.stop_bit();
    tick(2);
  endtask : bus_read

  // one data byte; enables are taken when the write ends
  task automatic bus_write(input logic [1:0] en);
    logic [7:0] rx;
    logic       ack;
    ctrl.host_enable = en;
    lnbfs_host_model_i.start_bit();
    lnbfs_host_model_i.xfer({ADDR, 1'h0}, 1'h1, rx, ack);
    lnbfs_host_model_i.xfer(8'h5A, 1'h1, rx, ack);
    lnbfs_host_model_i.stop_bit();
    tick(2);
    check("enables", {6'h00, out_enable}, {6'h00, en});
  endtask : bus_write

  task automatic t_enable();
    bus_write(2'h3);
    tick(5);
    check("primary clear", prim, 8'h00);
    check("secondary clear", sec, 8'h00);
  endtask : t_enable

  // which 0 is overtemperature, 1 is undervoltage
  task automatic t_fault(input int which);
    logic [7:0] f;
    f = 8'h33 | (8'h40 << which);
    t_enable();
    sense[1 - which] = 1'h1;
    tick(5);
    check("fault set", prim, f);
    bus_read(2, '{f, 8'h00, 8'h00});
    check("fault still on", prim, f);
    sense[1 - which] = 1'h0;
    tick(40);
    check("fault latched", prim, f);
    check("no self recovery", {6'h00, out_enable}, 8'h00);
    bus_read(1, '{f, 8'h00, 8'h00});
    check("fault cleared", prim, 8'h33);
  endtask : t_fault

  // short overload ignored, long one trips channel 2 only
  task automatic t_overcurrent();
    t_enable();
    sense.over_current = 2'h2;
    tick(10);
    sense.over_current = 2'h0;
    tick(30);
    check("short overload", prim, 8'h00);
    sense.over_current = 2'h2;
    tick(28);
    check("overload trip", prim, 8'h2A);
    check("ch1 kept on", {6'h00, out_enable}, 8'h01);
    bus_read(1, '{8'h2A, 8'h00, 8'h00});
    check("overcurrent cleared", prim, 8'h22);
    sense.over_current = 2'h0;
  endtask : t_overcurrent

  task automatic t_power();
    for (int ch = 0; ch < 2; ch++)
    begin
      sense.below_85[ch] = 1'h1;
      sense.within_90[ch] = 1'h0;
      tick(5);
      check("power bad set", prim, 8'h10 << ch);
      sense.below_85[ch] = 1'h0;
      tick(5);
      check("power bad held", prim, 8'h10 << ch);
      sense.within_90[ch] = 1'h1;
      tick(5);
      check("power bad clear", prim, 8'h00);
    end
  endtask : t_power

  task automatic t_cable();
    ctrl.cable_test = 2'h1;
    sense.above_21v[0] = 1'h1;
    sense.below_19v95[0] = 1'h0;
    tick(5);
    check("test source", {6'h00, test_src_on}, 8'h01);
    check("cable open", sec, 8'h01);
    sense.above_21v[0] = 1'h0;
    tick(5);
    check("cable open held", sec, 8'h01);
    sense.below_19v95[0] = 1'h1;
    tick(5);
    check("cable open clear", sec, 8'h00);
    ctrl.cable_test = 2'h0;
    sense.tone_at_out = 2'h2;
    tick(5);
    bus_read(3, '{8'h00, 8'h08, 8'h00});
    bus_read(2, '{8'h00, 8'h08, 8'h00});
    sense.tone_at_out = 2'h0;
    tick(5);
    check("tone gone", sec, 8'h00);
  endtask : t_cable

  initial
  begin
    reset_n = 1'h0;
    sense   = 14'h0330;  // outputs in range, cables connected, no faults
    ctrl    = 4'h0;
    tick(4);
    reset_n = 1'h1;
    tick(4);
    check("primary reset", prim, 8'h33);
    bus_read(3, '{8'h33, 8'h00, 8'h33});
    t_enable();
    t_power();
    t_cable();
    t_fault(0);
    t_fault(1);
    t_overcurrent();
    bus_write(2'h0);
    check("host disable", prim, 8'h33);
    close_out();
  end
endmodule : lnbfs_status_regs_tb_top
`default_nettype wire

// file: verilog/lnbfs_pkg.sv
`default_nettype none
package lnbfs_pkg;

  // channel count and serial framing
  localparam int         CH_COUNT       = 2;
  localparam logic [3:0] BIT_NINTH      = 4'h8;
  localparam logic [6:0] DEV_ADDR_DFLT  = 7'h2A;  // arbitrary default, strap it per board

  // timing: reference clock and overcurrent persistence
  localparam int         REF_CLK_HZ     = 10_000_000;
  localparam int         OC_TIME_MS     = 48;
  localparam int         OC_LIMIT_CYC   = REF_CLK_HZ / 1000 * OC_TIME_MS;
  localparam int         OC_CNT_W       = 20;

  // field positions in the primary status byte (per-channel fields: channel 1 bit, channel 2 one higher)
  localparam int         POS_OUT_OFF    = 0;
  localparam int         POS_OVERCUR    = 2;
  localparam int         POS_POWER_BAD  = 4;
  localparam int         POS_OVERTEMP   = 6;
  localparam int         POS_SUPPLY_LOW = 7;

  // field positions in the secondary status byte
  localparam int         POS_CABLE_OPEN = 0;
  localparam int         POS_TONE_SEEN  = 2;

  // reset values of the two status bytes
  localparam logic [7:0] PRIMARY_RESET   = 8'h33;
  localparam logic [7:0] SECONDARY_RESET = 8'h00;

  // comparator outputs from the analog side, bit 0 is channel 1
  typedef struct packed {
    logic [1:0] over_current;
    logic [1:0] below_85;
    logic [1:0] within_90;
    logic [1:0] above_21v;
    logic [1:0] below_19v95;
    logic [1:0] tone_at_out;
    logic       overtemp;
    logic       supply_low;
  } lnbfs_sense_t;

  // fields from the control register decoder, same clock as this block
  typedef struct packed {
    logic [1:0] host_enable;
    logic [1:0] cable_test;
  } lnbfs_ctrl_t;

  // serial transaction states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_WRITE,
    ST_READ,
    ST_WAIT
  } lnbfs_state_t;

endpackage : lnbfs_pkg
`default_nettype wire

// file: verilog/lnbfs_status_regs.sv
`timescale 1ns/10ps
`default_nettype none
module lnbfs_status_regs #(
  parameter logic [lnbfs_pkg::OC_CNT_W-1:0] OC_LIMIT_CYC =
    lnbfs_pkg::OC_CNT_W'(lnbfs_pkg::OC_LIMIT_CYC),
  parameter logic [6:0]                     DEV_ADDR     = lnbfs_pkg::DEV_ADDR_DFLT
) (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   reset_n,
  // two-wire serial bus, link_clk is the serial clock pin
  input  wire logic                   link_clk,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe_n,
  // analog comparators and control decoder
  input  wire lnbfs_pkg::lnbfs_sense_t sense_raw,
  input  wire lnbfs_pkg::lnbfs_ctrl_t  ctrl,
  // regulator steering
  output logic [1:0]                  out_enable,
  output logic [1:0]                  linreg_off,
  output logic [1:0]                  test_src_on,
  output logic                        write_end,
  // status bytes as seen by the host
  output logic [7:0]                  fault_status_primary,
  output logic [7:0]                  link_status_secondary
);

  // link domain: capture each data bit on the serial clock rise with a toggle
  logic link_bit_q;
  logic link_tgl_q;

  // async clear here only because the serial clock may stand still during reset
  always_ff @(posedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      link_bit_q <= 1'b0;
      link_tgl_q <= 1'b0;
    end
    else
    begin
      link_bit_q <= sda_in;
      link_tgl_q <= ~link_tgl_q;
    end
  end

  // pin and toggle synchronisers, the first stage feeds only the second
  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;
  logic tgl_m_q, tgl_s_q, tgl_p_q;
  lnbfs_pkg::lnbfs_sense_t sense_m_q, sense_s_q;

  always_ff @(posedge ref_clk)
  begin
    scl_m_q   <= link_clk;
    scl_s_q   <= scl_m_q;
    scl_p_q   <= scl_s_q;
    sda_m_q   <= sda_in;
    sda_s_q   <= sda_m_q;
    sda_p_q   <= sda_s_q;
    tgl_m_q   <= link_tgl_q;
    tgl_s_q   <= tgl_m_q;
    tgl_p_q   <= tgl_s_q;
    sense_m_q <= sense_raw;
    sense_s_q <= sense_m_q;
  end

  // bus conditions seen in the reference domain
  wire start_w    = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire stop_w     = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  wire scl_fall_w = scl_p_q & ~scl_s_q;
  wire bit_evt_w  = tgl_s_q ^ tgl_p_q;
  // the captured bit is stable for a whole serial clock, far longer than the toggle delay
  wire bit_val_w  = link_bit_q;

  // transaction state
  lnbfs_pkg::lnbfs_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] rx_q, rx_d;
  logic [7:0] tx_q, tx_d;
  logic       sel_q, sel_d;
  logic       drive_q, drive_d;
  logic       read_ninth;
  logic       write_end_w;

  // flag registers
  logic [1:0] on_q, on_d;
  logic [1:0] off_q, off_d;
  logic [1:0] ocf_q, ocf_d;
  logic [1:0] pbad_q, pbad_d;
  logic [1:0] cab_q, cab_d;
  logic [1:0] tone_q, tone_d;
  logic       hot_q, hot_d;
  logic       uvl_q, uvl_d;
  logic [1:0] trip_w;
  logic [7:0] prim_d_w, sec_d_w, prim_q_w, sec_q_w;

  // shutdown sources shared by both channels
  wire kill_all_w = sense_s_q.overtemp | sense_s_q.supply_low;

  // byte decode helpers
  wire [7:0] tx_sh_w    = tx_q << cnt_q[2:0];
  wire       addr_hit_w = (rx_q[7:1] == DEV_ADDR);
  wire       ninth_w    = (cnt_q == lnbfs_pkg::BIT_NINTH);
  wire [7:0] next_tx_w  = sel_q ? sec_d_w : prim_d_w;

  // protocol engine: framing, address match, byte alternation and bit drive
  always_comb
  begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    rx_d        = rx_q;
    tx_d        = tx_q;
    sel_d       = sel_q;
    drive_d     = drive_q;
    read_ninth  = 1'b0;
    write_end_w = 1'b0;
    if (start_w || stop_w)
    begin
      // a repeated start also closes a write in progress
      write_end_w = (state_q == lnbfs_pkg::ST_WRITE);
      state_d     = start_w ? lnbfs_pkg::ST_ADDR : lnbfs_pkg::ST_IDLE;
      cnt_d       = 4'h0;
      sel_d       = 1'b0;
      drive_d     = 1'b0;
    end
    else if (bit_evt_w && state_q != lnbfs_pkg::ST_IDLE)
    begin
      if (!ninth_w)
      begin
        cnt_d = cnt_q + 4'h1;
        rx_d  = {rx_q[6:0], bit_val_w};
      end
      else
      begin
        cnt_d = 4'h0;
        case (state_q)
          lnbfs_pkg::ST_ADDR:
          begin
            if (!addr_hit_w)
              state_d = lnbfs_pkg::ST_WAIT;
            else if (rx_q[0])
            begin
              state_d = lnbfs_pkg::ST_READ;
              tx_d    = prim_d_w;
              sel_d   = 1'b1;
            end
            else
              state_d = lnbfs_pkg::ST_WRITE;
          end
          lnbfs_pkg::ST_READ:
          begin
            read_ninth = 1'b1;
            tx_d       = next_tx_w;
            sel_d      = ~sel_q;
            if (bit_val_w)
              state_d = lnbfs_pkg::ST_WAIT;
          end
          default:
          begin
            state_d = state_q;
          end
        endcase
      end
    end
    else if (scl_fall_w)
    begin
      // change the drive only while serial clock is low, after the slave sees the fall
      case (state_q)
        lnbfs_pkg::ST_ADDR:  drive_d = ninth_w & addr_hit_w;
        lnbfs_pkg::ST_WRITE: drive_d = ninth_w;
        lnbfs_pkg::ST_READ:  drive_d = ~ninth_w & ~tx_sh_w[7];
        default:             drive_d = 1'b0;
      endcase
    end
  end

  // protocol registers
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      state_q <= lnbfs_pkg::ST_IDLE;
      cnt_q   <= 4'h0;
      rx_q    <= 8'h00;
      tx_q    <= 8'h00;
      sel_q   <= 1'b0;
      drive_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      rx_q    <= rx_d;
      tx_q    <= tx_d;
      sel_q   <= sel_d;
      drive_q <= drive_d;
    end
  end

  // per-channel flags; channel 2 is the same logic one bit higher
  genvar ch;
  generate
    for (ch = 0; ch < lnbfs_pkg::CH_COUNT; ch++)
    begin : g_ch
      logic [lnbfs_pkg::OC_CNT_W-1:0] occ_q;
      wire oc_live_w = sense_s_q.over_current[ch] & on_q[ch];

      // persistence timer restarts whenever the overcurrent goes away
      always_ff @(posedge ref_clk)
      begin
        if (!reset_n || !oc_live_w)
          occ_q <= '0;
        else if (occ_q != OC_LIMIT_CYC)
          occ_q <= occ_q + 1'b1;
      end

      assign trip_w[ch] = oc_live_w & (occ_q == OC_LIMIT_CYC);

      // output stays off after any shutdown until the host writes it on again
      assign on_d[ch] = (trip_w[ch] | kill_all_w) ? 1'b0 :
                        write_end_w ? ctrl.host_enable[ch] : on_q[ch];
      // fault sets; a write leaves it set only if the host kept the output off
      assign off_d[ch] = trip_w[ch] | kill_all_w |
                         (write_end_w ? ~ctrl.host_enable[ch] : off_q[ch]);
      // a trip in the very read cycle still shows; set beats clear
      assign ocf_d[ch] = trip_w[ch] | (ocf_q[ch] & ~read_ninth);
      assign pbad_d[ch] = ~on_q[ch] | sense_s_q.below_85[ch] |
                          (pbad_q[ch] & ~sense_s_q.within_90[ch]);
      assign cab_d[ch] = ctrl.cable_test[ch] & (sense_s_q.above_21v[ch] |
                         (cab_q[ch] & ~sense_s_q.below_19v95[ch]));
      assign tone_d[ch] = sense_s_q.tone_at_out[ch];

      // status byte assembly, d side feeds the read shifter, q side the ports
      assign prim_d_w[lnbfs_pkg::POS_OUT_OFF + ch]    = off_d[ch];
      assign prim_d_w[lnbfs_pkg::POS_OVERCUR + ch]    = ocf_d[ch];
      assign prim_d_w[lnbfs_pkg::POS_POWER_BAD + ch]  = pbad_d[ch];
      assign prim_q_w[lnbfs_pkg::POS_OUT_OFF + ch]    = off_q[ch];
      assign prim_q_w[lnbfs_pkg::POS_OVERCUR + ch]    = ocf_q[ch];
      assign prim_q_w[lnbfs_pkg::POS_POWER_BAD + ch]  = pbad_q[ch];
      assign sec_d_w[lnbfs_pkg::POS_CABLE_OPEN + ch]  = cab_d[ch];
      assign sec_d_w[lnbfs_pkg::POS_TONE_SEEN + ch]   = tone_d[ch];
      assign sec_q_w[lnbfs_pkg::POS_CABLE_OPEN + ch]  = cab_q[ch];
      assign sec_q_w[lnbfs_pkg::POS_TONE_SEEN + ch]   = tone_q[ch];
    end
  endgenerate

  // shared latched faults: resampled at the ninth rise of a read, set wins
  assign hot_d = sense_s_q.overtemp | (hot_q & ~read_ninth);
  assign uvl_d = sense_s_q.supply_low | (uvl_q & ~read_ninth);

  assign prim_d_w[lnbfs_pkg::POS_OVERTEMP]   = hot_d;
  assign prim_d_w[lnbfs_pkg::POS_SUPPLY_LOW] = uvl_d;
  assign prim_q_w[lnbfs_pkg::POS_OVERTEMP]   = hot_q;
  assign prim_q_w[lnbfs_pkg::POS_SUPPLY_LOW] = uvl_q;
  assign sec_d_w[7:4] = 4'h0;
  assign sec_q_w[7:4] = 4'h0;

  // flag registers; reset gives outputs off, power bad set, all else clear
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      on_q   <= 2'h0;
      off_q  <= lnbfs_pkg::PRIMARY_RESET[1:0];
      ocf_q  <= lnbfs_pkg::PRIMARY_RESET[3:2];
      pbad_q <= lnbfs_pkg::PRIMARY_RESET[5:4];
      cab_q  <= lnbfs_pkg::SECONDARY_RESET[1:0];
      tone_q <= lnbfs_pkg::SECONDARY_RESET[3:2];
      hot_q  <= lnbfs_pkg::PRIMARY_RESET[6];
      uvl_q  <= lnbfs_pkg::PRIMARY_RESET[7];
    end
    else
    begin
      on_q   <= on_d;
      off_q  <= off_d;
      ocf_q  <= ocf_d;
      pbad_q <= pbad_d;
      cab_q  <= cab_d;
      tone_q <= tone_d;
      hot_q  <= hot_d;
      uvl_q  <= uvl_d;
    end
  end

  // regulator steering and write strobe registers
  logic [1:0] linreg_off_q;
  logic [1:0] test_src_q;
  logic       write_end_q;

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      linreg_off_q <= 2'h3;
      test_src_q   <= 2'h0;
      write_end_q  <= 1'b0;
    end
    else
    begin
      linreg_off_q <= ~on_d | ctrl.cable_test;
      test_src_q   <= on_d & ctrl.cable_test;
      write_end_q  <= write_end_w;
    end
  end

  // the output-off flag has no path to any interrupt; only host polling sees it
  // all flags but tone seen are zero when outputs are on, in range and fault free
  assign fault_status_primary  = prim_q_w;
  assign link_status_secondary = sec_q_w;
  assign out_enable            = on_q;
  assign linreg_off            = linreg_off_q;
  assign test_src_on           = test_src_q;
  assign write_end             = write_end_q;
  assign sda_out               = 1'b0;     // open drain: only ever pulls low
  assign sda_oe_n              = ~drive_q;

endmodule : lnbfs_status_regs
`default_nettype wire
